// [common/cevi_pkg.sv]
/*
  Constants and types shared by the CAN event/interrupt logic and its system-side partner.
  Assumes a single 125 MHz clock (clk_sys) and an asynchronous active-low reset on both ends.
*/
package cevi_pkg;

  localparam int SLOTS = 16;
  localparam int SLOT_W = 4;
  localparam int ERR_W = 3;
  localparam int LINES = 3;
  localparam int DATA_W = 16;
  localparam int MSTAT_W = 8;

  // error event bit positions
  localparam int ERR_BUS = 0;
  localparam int ERR_PASSIVE = 1;
  localparam int ERR_BUSOFF = 2;

  // request line / latch indices
  localparam int LINE_RX = 0;
  localparam int LINE_TX = 1;
  localparam int LINE_ERR = 2;

  // module_control_one field
  localparam int CTL_SPLIT_BIT = 0;

  // module_status fields
  localparam int STS_RECEIVING = 0;
  localparam int STS_RX_SUCC = 1;
  localparam int STS_TX_SUCC = 2;
  localparam int STS_BUS_ERR = 3;
  localparam int STS_SLOT_LSB = 4;

  // reset values
  localparam logic [DATA_W-1:0] RST_WORD = 16'h0000;
  localparam logic [ERR_W-1:0] RST_ERR = 3'h0;
  localparam logic [LINES-1:0] RST_LINES = 3'h0;
  localparam logic [LINES-1:0] RST_ARMED = 3'h7;
  localparam logic [SLOT_W-1:0] RST_SLOT = 4'h0;
  localparam logic [DATA_W-LINES-1:0] PAD_LINES = 13'h0000;
  localparam logic [DATA_W-ERR_W-1:0] PAD_ERR = 13'h0000;

  // software-visible registers reached over the write port
  typedef enum logic [3:0] {
    REG_SLOT_CONTROL,
    REG_MODULE_STATUS,
    REG_SLOT_EVENT_STATUS,
    REG_ERROR_EVENT_STATUS,
    REG_SLOT_EVENT_MASK,
    REG_ERROR_EVENT_MASK,
    REG_MODULE_CONTROL_ONE,
    REG_REQUEST_LATCH,
    REG_REQUEST_LATCH_ENABLE,
    REG_NEW_MESSAGE
  } cevi_reg_t;

endpackage : cevi_pkg

// [common/cevi_if.sv]
/*
  Link between the CAN event/interrupt logic (dev) and the engine/software/interrupt side (sys).
  Assumes both ends sample every signal on the same clk_sys rising edge.
*/
interface cevi_if;
  // register write port, clear-by-zero where noted in the device
  logic wr_valid;
  cevi_pkg::cevi_reg_t wr_reg;
  logic [cevi_pkg::DATA_W-1:0] wr_data;
  // protocol engine events, one-cycle pulses
  logic rx_start;
  logic rx_done;
  logic rx_stored;
  logic [cevi_pkg::SLOT_W-1:0] rx_slot;
  logic tx_done;
  logic [cevi_pkg::SLOT_W-1:0] tx_slot;
  logic bus_err;
  logic err_passive_entry;
  logic bus_off_entry;
  // interrupt acknowledge of pending flags
  logic [cevi_pkg::LINES-1:0] pend_ack;
  // device state seen by the system side
  logic [cevi_pkg::MSTAT_W-1:0] module_status;
  logic [cevi_pkg::SLOTS-1:0] slot_accept;
  logic [cevi_pkg::SLOTS-1:0] slot_update_in_progress;
  logic [cevi_pkg::SLOTS-1:0] new_message_flag;
  logic [cevi_pkg::SLOTS-1:0] sent_flag;
  logic [cevi_pkg::SLOTS-1:0] slot_event_status;
  logic [cevi_pkg::ERR_W-1:0] error_event_status;
  logic [cevi_pkg::LINES-1:0] request_latch;
  logic [cevi_pkg::LINES-1:0] pending_flag;
  logic [cevi_pkg::LINES-1:0] irq_line;
  logic error_frame_start;

  modport dev (
    input wr_valid, wr_reg, wr_data, rx_start, rx_done, rx_stored, rx_slot, tx_done, tx_slot,
    input bus_err, err_passive_entry, bus_off_entry, pend_ack,
    output module_status, slot_accept, slot_update_in_progress, new_message_flag, sent_flag,
    output slot_event_status, error_event_status, request_latch, pending_flag, irq_line,
    output error_frame_start
  );

  modport sys (
    output wr_valid, wr_reg, wr_data, rx_start, rx_done, rx_stored, rx_slot, tx_done, tx_slot,
    output bus_err, err_passive_entry, bus_off_entry, pend_ack,
    input module_status, slot_accept, slot_update_in_progress, new_message_flag, sent_flag,
    input slot_event_status, error_event_status, request_latch, pending_flag, irq_line,
    input error_frame_start
  );
endinterface : cevi_if

// [core/cevi_device.sv]
/*
  CAN receive/transmit status flags, bus-error flagging and interrupt request generation.
  Assumes engine events are single-cycle pulses on clk_sys and that software clears by writing 0.
*/
module cevi_device #(
  parameter int N_SLOTS = cevi_pkg::SLOTS // must match the link width
) (
  input wire logic clk_sys, // can clock
  input wire logic rst_n, // async reset, active low
  cevi_if.dev link, // engine, software and interrupt side
  output logic [cevi_pkg::LINES-1:0] int_req // pending flags to the cpu
);

  if (N_SLOTS != cevi_pkg::SLOTS) begin : g_bad_slots
    $error("cevi_device: N_SLOTS must equal the link slot count");
  end

  typedef struct packed {
    logic [cevi_pkg::SLOTS-1:0] rx_req;
    logic [cevi_pkg::SLOTS-1:0] uip;
    logic [cevi_pkg::SLOTS-1:0] newmsg;
    logic [cevi_pkg::SLOTS-1:0] sent;
    logic [cevi_pkg::SLOTS-1:0] slot_tx;
    logic [cevi_pkg::SLOTS-1:0] ses;
    logic [cevi_pkg::SLOTS-1:0] sem;
    logic [cevi_pkg::ERR_W-1:0] ees;
    logic [cevi_pkg::ERR_W-1:0] eem;
    logic split;
    logic [cevi_pkg::LINES-1:0] len;
    logic [cevi_pkg::LINES-1:0] latch;
    logic [cevi_pkg::LINES-1:0] pend;
    logic [cevi_pkg::LINES-1:0] armed;
    logic receiving;
    logic rx_succ;
    logic tx_succ;
    logic bus_err_st;
    logic [cevi_pkg::SLOT_W-1:0] last_slot;
    logic [cevi_pkg::SLOT_W-1:0] rx_hold;
    logic err_frame;
  } cevi_dev_state_t;

  cevi_dev_state_t s_q;
  cevi_dev_state_t s_d;

  logic raw_all;
  logic [cevi_pkg::LINES-1:0] raw;
  logic [cevi_pkg::LINES-1:0] rearm;
  logic [cevi_pkg::LINES-1:0] fire;

  // masked sources from registered status, one shared OR in combined mode
  always_comb begin
    raw_all = (|(s_q.ses & s_q.sem)) | (|(s_q.ees & s_q.eem));
    if (s_q.split) begin
      raw[cevi_pkg::LINE_RX] = |(s_q.ses & s_q.sem & ~s_q.slot_tx);
      raw[cevi_pkg::LINE_TX] = |(s_q.ses & s_q.sem & s_q.slot_tx);
      raw[cevi_pkg::LINE_ERR] = |(s_q.ees & s_q.eem);
      // rx/tx come back on the latch alone; error also waits for its sources
      rearm[cevi_pkg::LINE_RX] = ~s_q.latch[cevi_pkg::LINE_RX];
      rearm[cevi_pkg::LINE_TX] = ~s_q.latch[cevi_pkg::LINE_TX];
      rearm[cevi_pkg::LINE_ERR] = ~s_q.latch[cevi_pkg::LINE_ERR] & ~raw[cevi_pkg::LINE_ERR];
    end else begin
      raw = {cevi_pkg::LINES{raw_all}};
      rearm = {cevi_pkg::LINES{~(|s_q.latch) & ~raw_all}};
    end
    // an armed line with an active source is a rising request edge
    fire = s_q.armed & raw;
  end

  // software writes first, hardware sets afterwards so a set wins over a clear
  always_comb begin
    s_d = s_q;
    s_d.err_frame = 1'b0;
    if (link.wr_valid) begin
      if (link.wr_reg == cevi_pkg::REG_SLOT_CONTROL) begin
        s_d.rx_req = link.wr_data;
      end else if (link.wr_reg == cevi_pkg::REG_MODULE_STATUS) begin
        s_d.rx_succ = s_q.rx_succ & link.wr_data[cevi_pkg::STS_RX_SUCC];
        s_d.tx_succ = s_q.tx_succ & link.wr_data[cevi_pkg::STS_TX_SUCC];
        s_d.bus_err_st = s_q.bus_err_st & link.wr_data[cevi_pkg::STS_BUS_ERR];
      end else if (link.wr_reg == cevi_pkg::REG_SLOT_EVENT_STATUS) begin
        s_d.ses = s_q.ses & link.wr_data;
      end else if (link.wr_reg == cevi_pkg::REG_ERROR_EVENT_STATUS) begin
        s_d.ees = s_q.ees & link.wr_data[cevi_pkg::ERR_W-1:0];
      end else if (link.wr_reg == cevi_pkg::REG_SLOT_EVENT_MASK) begin
        s_d.sem = link.wr_data;
      end else if (link.wr_reg == cevi_pkg::REG_ERROR_EVENT_MASK) begin
        s_d.eem = link.wr_data[cevi_pkg::ERR_W-1:0];
      end else if (link.wr_reg == cevi_pkg::REG_MODULE_CONTROL_ONE) begin
        s_d.split = link.wr_data[cevi_pkg::CTL_SPLIT_BIT];
      end else if (link.wr_reg == cevi_pkg::REG_REQUEST_LATCH) begin
        s_d.latch = s_q.latch & link.wr_data[cevi_pkg::LINES-1:0];
      end else if (link.wr_reg == cevi_pkg::REG_REQUEST_LATCH_ENABLE) begin
        s_d.len = link.wr_data[cevi_pkg::LINES-1:0];
      end else if (link.wr_reg == cevi_pkg::REG_NEW_MESSAGE) begin
        s_d.newmsg = s_q.newmsg & link.wr_data;
        s_d.sent = s_q.sent & link.wr_data;
      end
    end
    // acknowledge by the interrupt controller drops pending flags only
    s_d.pend = s_d.pend & ~link.pend_ack;

    // frame reception sequence
    if (link.rx_start) begin
      s_d.receiving = 1'b1;
    end
    if (link.rx_done) begin
      s_d.receiving = 1'b0;
      if (s_q.rx_req[link.rx_slot]) begin
        s_d.uip[link.rx_slot] = 1'b1;
        s_d.newmsg[link.rx_slot] = 1'b1;
        s_d.rx_succ = 1'b1;
        s_d.rx_hold = link.rx_slot;
      end
    end
    if (link.rx_stored) begin
      s_d.uip[s_q.rx_hold] = 1'b0;
      s_d.ses[s_q.rx_hold] = 1'b1;
      s_d.slot_tx[s_q.rx_hold] = 1'b0;
      s_d.last_slot = s_q.rx_hold;
    end
    // transmit completion; wins the slot number if both land together
    if (link.tx_done) begin
      s_d.sent[link.tx_slot] = 1'b1;
      s_d.tx_succ = 1'b1;
      s_d.ses[link.tx_slot] = 1'b1;
      s_d.slot_tx[link.tx_slot] = 1'b1;
      s_d.last_slot = link.tx_slot;
    end
    // error sources
    if (link.bus_err) begin
      s_d.bus_err_st = 1'b1;
      s_d.ees[cevi_pkg::ERR_BUS] = 1'b1;
      s_d.err_frame = 1'b1;
    end
    if (link.err_passive_entry) begin
      s_d.ees[cevi_pkg::ERR_PASSIVE] = 1'b1;
    end
    if (link.bus_off_entry) begin
      s_d.ees[cevi_pkg::ERR_BUSOFF] = 1'b1;
    end

    // request edges: latch set, pending set where its latch enable is set, line disarmed until re-armed
    for (int k = 0; k < cevi_pkg::LINES; k++) begin
      if (fire[k]) begin
        s_d.latch[k] = 1'b1;
        s_d.armed[k] = 1'b0;
        if (s_q.len[k]) begin
          s_d.pend[k] = 1'b1;
        end
      end else if (rearm[k]) begin
        s_d.armed[k] = 1'b1;
      end
    end
  end

  // all state in one register; constants only under reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q.rx_req <= cevi_pkg::RST_WORD;
      s_q.uip <= cevi_pkg::RST_WORD;
      s_q.newmsg <= cevi_pkg::RST_WORD;
      s_q.sent <= cevi_pkg::RST_WORD;
      s_q.slot_tx <= cevi_pkg::RST_WORD;
      s_q.ses <= cevi_pkg::RST_WORD;
      s_q.sem <= cevi_pkg::RST_WORD;
      s_q.ees <= cevi_pkg::RST_ERR;
      s_q.eem <= cevi_pkg::RST_ERR;
      s_q.split <= 1'b0;
      s_q.len <= cevi_pkg::RST_LINES;
      s_q.latch <= cevi_pkg::RST_LINES;
      s_q.pend <= cevi_pkg::RST_LINES;
      s_q.armed <= cevi_pkg::RST_ARMED;
      s_q.receiving <= 1'b0;
      s_q.rx_succ <= 1'b0;
      s_q.tx_succ <= 1'b0;
      s_q.bus_err_st <= 1'b0;
      s_q.last_slot <= cevi_pkg::RST_SLOT;
      s_q.rx_hold <= cevi_pkg::RST_SLOT;
      s_q.err_frame <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  always_comb begin
    link.module_status = '0;
    link.module_status[cevi_pkg::STS_RECEIVING] = s_q.receiving;
    link.module_status[cevi_pkg::STS_RX_SUCC] = s_q.rx_succ;
    link.module_status[cevi_pkg::STS_TX_SUCC] = s_q.tx_succ;
    link.module_status[cevi_pkg::STS_BUS_ERR] = s_q.bus_err_st;
    link.module_status[cevi_pkg::STS_SLOT_LSB +: cevi_pkg::SLOT_W] = s_q.last_slot;
  end

  assign link.slot_accept = s_q.rx_req;
  assign link.slot_update_in_progress = s_q.uip;
  assign link.new_message_flag = s_q.newmsg;
  assign link.sent_flag = s_q.sent;
  assign link.slot_event_status = s_q.ses;
  assign link.error_event_status = s_q.ees;
  assign link.request_latch = s_q.latch;
  assign link.pending_flag = s_q.pend;
  assign link.irq_line = ~s_q.armed; // request held while disarmed
  assign link.error_frame_start = s_q.err_frame;
  assign int_req = s_q.pend;

endmodule : cevi_device

// [core/cevi_system.sv]
/*
  System side of the CAN event/interrupt link: passes engine events, forwards software writes
  and runs the service sequence that clears latch, status bits and pending flag in order.
  Assumes the user side holds sw_wr_valid until sw_ready was seen with it.
*/
module cevi_system (
  input wire logic clk_sys, // can clock
  input wire logic rst_n, // async reset, active low
  cevi_if.sys link, // to the event/interrupt logic
  input wire logic sw_wr_valid, // software write request
  input wire cevi_pkg::cevi_reg_t sw_wr_reg, // register selected
  input wire logic [cevi_pkg::DATA_W-1:0] sw_wr_data, // write data
  output logic sw_ready, // write taken this cycle when valid
  input wire logic svc_req, // start a service sequence
  input wire logic [cevi_pkg::LINES-1:0] svc_latch_keep, // 0 clears that latch
  input wire logic [cevi_pkg::SLOTS-1:0] svc_slot_keep, // 0 clears that slot event bit
  input wire logic [cevi_pkg::ERR_W-1:0] svc_err_keep, // 0 clears that error event bit
  output logic svc_busy, // service sequence running
  input wire logic ev_rx_start, // engine: reception begins
  input wire logic ev_rx_done, // engine: reception ends
  input wire logic ev_rx_stored, // engine: data written to slot
  input wire logic [cevi_pkg::SLOT_W-1:0] ev_rx_slot, // receiving slot
  input wire logic ev_tx_done, // engine: transmission ends
  input wire logic [cevi_pkg::SLOT_W-1:0] ev_tx_slot, // transmitting slot
  input wire logic ev_bus_err, // engine: bus error seen
  input wire logic ev_err_passive, // engine: entered error-passive
  input wire logic ev_bus_off // engine: entered bus-off
);

  typedef enum logic [2:0] {
    SYS_IDLE,
    SYS_CLR_LATCH,
    SYS_CLR_SLOT,
    SYS_CLR_ERR,
    SYS_ACK
  } cevi_sys_state_t;

  typedef struct packed {
    cevi_sys_state_t state;
    logic [cevi_pkg::LINES-1:0] latch_keep;
    logic [cevi_pkg::SLOTS-1:0] slot_keep;
    logic [cevi_pkg::ERR_W-1:0] err_keep;
    logic wr_valid;
    cevi_pkg::cevi_reg_t wr_reg;
    logic [cevi_pkg::DATA_W-1:0] wr_data;
    logic [cevi_pkg::LINES-1:0] ack;
  } cevi_sys_regs_t;

  cevi_sys_regs_t r_q;
  cevi_sys_regs_t r_d;

  // latch is cleared before status so no fresh edge slips in between
  always_comb begin
    r_d = r_q;
    r_d.wr_valid = 1'b0;
    r_d.ack = cevi_pkg::RST_LINES;
    case (r_q.state)
      SYS_IDLE: begin
        if (svc_req) begin
          r_d.state = SYS_CLR_LATCH;
          r_d.latch_keep = svc_latch_keep;
          r_d.slot_keep = svc_slot_keep;
          r_d.err_keep = svc_err_keep;
        end else if (sw_wr_valid) begin
          r_d.wr_valid = 1'b1;
          r_d.wr_reg = sw_wr_reg;
          r_d.wr_data = sw_wr_data;
        end
      end
      SYS_CLR_LATCH: begin
        r_d.wr_valid = 1'b1;
        r_d.wr_reg = cevi_pkg::REG_REQUEST_LATCH;
        r_d.wr_data = {cevi_pkg::PAD_LINES, r_q.latch_keep};
        r_d.state = SYS_CLR_SLOT;
      end
      SYS_CLR_SLOT: begin
        r_d.wr_valid = 1'b1;
        r_d.wr_reg = cevi_pkg::REG_SLOT_EVENT_STATUS;
        r_d.wr_data = r_q.slot_keep;
        r_d.state = SYS_CLR_ERR;
      end
      SYS_CLR_ERR: begin
        r_d.wr_valid = 1'b1;
        r_d.wr_reg = cevi_pkg::REG_ERROR_EVENT_STATUS;
        r_d.wr_data = {cevi_pkg::PAD_ERR, r_q.err_keep};
        r_d.state = SYS_ACK;
      end
      SYS_ACK: begin
        r_d.ack = ~r_q.latch_keep;
        r_d.state = SYS_IDLE;
      end
      default: begin
        r_d.state = SYS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      r_q.state <= SYS_IDLE;
      r_q.latch_keep <= cevi_pkg::RST_LINES;
      r_q.slot_keep <= cevi_pkg::RST_WORD;
      r_q.err_keep <= cevi_pkg::RST_ERR;
      r_q.wr_valid <= 1'b0;
      r_q.wr_reg <= cevi_pkg::REG_SLOT_CONTROL;
      r_q.wr_data <= cevi_pkg::RST_WORD;
      r_q.ack <= cevi_pkg::RST_LINES;
    end else begin
      r_q <= r_d;
    end
  end

  // writes only while idle; a service request takes priority
  assign sw_ready = (r_q.state == SYS_IDLE) && !svc_req;
  assign svc_busy = (r_q.state != SYS_IDLE);
  assign link.wr_valid = r_q.wr_valid;
  assign link.wr_reg = r_q.wr_reg;
  assign link.wr_data = r_q.wr_data;
  assign link.pend_ack = r_q.ack;

  // engine events go through untouched, same cycle
  assign link.rx_start = ev_rx_start;
  assign link.rx_done = ev_rx_done;
  assign link.rx_stored = ev_rx_stored;
  assign link.rx_slot = ev_rx_slot;
  assign link.tx_done = ev_tx_done;
  assign link.tx_slot = ev_tx_slot;
  assign link.bus_err = ev_bus_err;
  assign link.err_passive_entry = ev_err_passive;
  assign link.bus_off_entry = ev_bus_off;

endmodule : cevi_system

// [bench/cevi_chk.sv]
/*
  Concurrent checks on the signals of the cevi link between the event logic and its system side.
  Assumes one clk_sys domain and rst_n asynchronous, active low; instantiated beside the interface.
*/
module cevi_chk (
  input wire logic clk_sys, // clock
  input wire logic rst_n, // reset, active low
  input wire logic wr_valid, // register write
  input wire cevi_pkg::cevi_reg_t wr_reg, // register id
  input wire logic [15:0] wr_data, // write data
  input wire logic rx_start, // reception begins
  input wire logic rx_done, // reception ends
  input wire logic rx_stored, // data stored
  input wire logic [3:0] rx_slot, // receiving slot
  input wire logic tx_done, // transmission ends
  input wire logic [3:0] tx_slot, // sending slot
  input wire logic bus_err, // bus error seen
  input wire logic [7:0] module_status, // module flags
  input wire logic [15:0] slot_accept, // receive request
  input wire logic [15:0] slot_update_in_progress, // store busy
  input wire logic [15:0] new_message_flag, // new message
  input wire logic [15:0] sent_flag, // sent
  input wire logic [15:0] slot_event_status, // slot events
  input wire logic [2:0] error_event_status, // error events
  input wire logic [2:0] request_latch, // request latches
  input wire logic [2:0] pending_flag, // pending flags
  input wire logic [2:0] irq_line, // request lines
  input wire logic error_frame_start // error frame pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // shadow of split select and of the slot that the next store writes
  logic split_q;
  logic [3:0] cap_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      split_q <= 1'b0;
      cap_q <= 4'h0;
    end else begin
      if (wr_valid && wr_reg == cevi_pkg::REG_MODULE_CONTROL_ONE) split_q <= wr_data[0];
      if (rx_done && slot_accept[rx_slot]) cap_q <= rx_slot;
    end
  end

  a_rx_start_flag: assert property (rx_start |=> module_status[0])
    else $error("receiving flag not set");
  a_rx_done_flags: assert property (rx_done && slot_accept[rx_slot] |=> slot_update_in_progress[$past(rx_slot)]
    && new_message_flag[$past(rx_slot)] && module_status[1])
    else $error("reception end flags wrong");
  a_rx_store_slot: assert property (rx_stored && !tx_done |=> !slot_update_in_progress[cap_q]
    && slot_event_status[cap_q] && module_status[7:4] == cap_q)
    else $error("store end flags wrong");
  a_tx_done_flags: assert property (tx_done |=> sent_flag[$past(tx_slot)] && slot_event_status[$past(tx_slot)]
    && module_status[2] && module_status[7:4] == $past(tx_slot))
    else $error("transmit end flags wrong");
  a_bus_err_flags: assert property (bus_err |=> module_status[3] && error_event_status[0] && error_frame_start)
    else $error("bus error flags wrong");
  a_frame_cause: assert property (error_frame_start |-> $past(bus_err))
    else $error("error frame without bus error");
  // a latch sets exactly where its line rises, never while the line is held
  a_latch_on_edge: assert property ((request_latch & ~$past(request_latch)) == (irq_line & ~$past(irq_line)))
    else $error("latch set without request edge");
  a_comb_all_lines: assert property (!split_q && $rose(irq_line[0]) |-> irq_line == 3'h7)
    else $error("combined request not on all lines");
  a_hw_no_clear: assert property (!$past(wr_valid) |->
    (($past(slot_event_status) & ~slot_event_status) == 16'h0000)
    && (($past(error_event_status) & ~error_event_status) == 3'h0)
    && (($past(request_latch) & ~request_latch) == 3'h0))
    else $error("status or latch cleared by hardware");
  a_pend_with_latch: assert property (((pending_flag & ~$past(pending_flag))
    & ~(request_latch & ~$past(request_latch))) == 3'h0)
    else $error("pending set without latch edge");

  c_comb_fire: cover property (!split_q && $rose(irq_line[0]));
  c_split_err: cover property (split_q && $rose(irq_line[2]));
  c_rx_store: cover property (rx_stored);
  c_bus_err: cover property (bus_err);
endmodule : cevi_chk

// [bench/test_can_event_interrupt_logic.sv]
/*
  Self-checking bench: both ends of the cevi link joined by the interface, checker beside it.
  Assumes package, interface, design and checker are compiled before this file.
*/
module test_can_event_interrupt_logic;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    int kind;
    logic [3:0] slot;
    logic [15:0] ses;
    logic [2:0] ees;
  } cevi_row_t;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic sw_wr_valid = 1'b0, sw_ready, svc_req = 1'b0, svc_busy;
  cevi_pkg::cevi_reg_t sw_wr_reg = cevi_pkg::REG_SLOT_CONTROL;
  logic [15:0] sw_wr_data = 16'h0000, svc_slot_keep = 16'h0000;
  logic [2:0] svc_latch_keep = 3'h0, svc_err_keep = 3'h0, int_req;
  logic ev_rx_start = 1'b0, ev_rx_done = 1'b0, ev_rx_stored = 1'b0, ev_tx_done = 1'b0;
  logic ev_bus_err = 1'b0, ev_err_passive = 1'b0, ev_bus_off = 1'b0;
  logic [3:0] ev_slot = 4'h0;
  int fails = 0, cmp_count = 0;
  cevi_row_t rows [6];

  cevi_if lnk ();
  cevi_device #(.N_SLOTS(16)) cevi_device_i (.clk_sys(clk_sys), .rst_n(rst_n), .link(lnk.dev), .int_req(int_req));
  cevi_system cevi_system_i (.clk_sys(clk_sys), .rst_n(rst_n), .link(lnk.sys), .sw_wr_valid(sw_wr_valid),
    .sw_wr_reg(sw_wr_reg), .sw_wr_data(sw_wr_data), .sw_ready(sw_ready), .svc_req(svc_req),
    .svc_latch_keep(svc_latch_keep), .svc_slot_keep(svc_slot_keep), .svc_err_keep(svc_err_keep),
    .svc_busy(svc_busy), .ev_rx_start(ev_rx_start), .ev_rx_done(ev_rx_done), .ev_rx_stored(ev_rx_stored),
    .ev_rx_slot(ev_slot), .ev_tx_done(ev_tx_done), .ev_tx_slot(ev_slot), .ev_bus_err(ev_bus_err),
    .ev_err_passive(ev_err_passive), .ev_bus_off(ev_bus_off));
  cevi_chk cevi_chk_i (.clk_sys(clk_sys), .rst_n(rst_n), .wr_valid(lnk.wr_valid), .wr_reg(lnk.wr_reg),
    .wr_data(lnk.wr_data), .rx_start(lnk.rx_start), .rx_done(lnk.rx_done), .rx_stored(lnk.rx_stored),
    .rx_slot(lnk.rx_slot), .tx_done(lnk.tx_done), .tx_slot(lnk.tx_slot), .bus_err(lnk.bus_err),
    .module_status(lnk.module_status), .slot_accept(lnk.slot_accept),
    .slot_update_in_progress(lnk.slot_update_in_progress), .new_message_flag(lnk.new_message_flag),
    .sent_flag(lnk.sent_flag), .slot_event_status(lnk.slot_event_status),
    .error_event_status(lnk.error_event_status), .request_latch(lnk.request_latch),
    .pending_flag(lnk.pending_flag), .irq_line(lnk.irq_line), .error_frame_start(lnk.error_frame_start));

  // 125 MHz clock
  always #4 clk_sys = ~clk_sys;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done

  // software write, held until the system side takes it, then three cycles for the effect
  task automatic wr(input cevi_pkg::cevi_reg_t r, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    sw_wr_valid <= 1'b1;
    sw_wr_reg <= r;
    sw_wr_data <= d;
    @(posedge clk_sys);
    while (sw_ready !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk_sys);
    end
    chk(sw_ready, 1'b1);
    sw_wr_valid <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask : wr

  // one engine pulse; kinds 0 start, 1 done, 2 stored, 3 tx, 4 bus err, 5 passive, 6 bus-off
  task automatic ev(input int k, input logic [3:0] s);
    @(posedge clk_sys);
    ev_slot <= s;
    case (k)
      0: ev_rx_start <= 1'b1;
      1: ev_rx_done <= 1'b1;
      2: ev_rx_stored <= 1'b1;
      3: ev_tx_done <= 1'b1;
      4: ev_bus_err <= 1'b1;
      5: ev_err_passive <= 1'b1;
      default: ev_bus_off <= 1'b1;
    endcase
    @(posedge clk_sys);
    {ev_rx_start, ev_rx_done, ev_rx_stored, ev_tx_done, ev_bus_err, ev_err_passive, ev_bus_off} <= 7'h00;
    repeat (3) @(posedge clk_sys);
  endtask : ev

  // service sequence; keep bits at 0 clear, busy waited under a bound
  task automatic svc(input logic [2:0] lk, input logic [15:0] sk, input logic [2:0] ek);
    int n;
    n = 0;
    @(posedge clk_sys);
    svc_req <= 1'b1;
    svc_latch_keep <= lk;
    svc_slot_keep <= sk;
    svc_err_keep <= ek;
    @(posedge clk_sys);
    svc_req <= 1'b0;
    @(posedge clk_sys);
    chk({svc_busy, sw_ready}, 2'h2);
    while (svc_busy !== 1'b0 && n < 20) begin
      n++;
      @(posedge clk_sys);
    end
    chk(svc_busy, 1'b0);
    repeat (2) @(posedge clk_sys);
  endtask : svc

  // main sequence: table of sources in combined mode, then hand-written cases
  initial begin
    rows = '{'{2, 4'h3, 16'h0008, 3'h0}, '{3, 4'hF, 16'h8000, 3'h0}, '{4, 4'h0, 16'h0000, 3'h1},
      '{5, 4'h0, 16'h0000, 3'h2}, '{6, 4'h0, 16'h0000, 3'h4}, '{2, 4'h0, 16'h0001, 3'h0}};
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    chk({lnk.request_latch, lnk.irq_line, int_req, lnk.error_event_status, lnk.slot_event_status}, 28'h0);
    $display("reset check done");
    wr(cevi_pkg::REG_SLOT_CONTROL, 16'h7FFF);
    wr(cevi_pkg::REG_SLOT_EVENT_MASK, 16'hFFFF);
    wr(cevi_pkg::REG_ERROR_EVENT_MASK, 16'h0007);
    wr(cevi_pkg::REG_REQUEST_LATCH_ENABLE, 16'h0007);
    chk(lnk.slot_accept, 16'h7FFF);
    foreach (rows[i]) begin
      if (rows[i].kind == 2) begin
        ev(0, rows[i].slot);
        ev(1, rows[i].slot);
      end
      ev(rows[i].kind, rows[i].slot);
      chk(lnk.slot_event_status, rows[i].ses);
      chk(lnk.error_event_status, rows[i].ees);
      chk({lnk.request_latch, int_req, lnk.irq_line}, 9'h1FF);
      if (rows[i].kind < 4) begin
        chk(lnk.module_status[7:4], rows[i].slot);
        chk(rows[i].kind == 2 ? lnk.new_message_flag[rows[i].slot] : lnk.sent_flag[rows[i].slot], 1'b1);
      end
      svc(3'h0, 16'h0000, 3'h0);
      chk({lnk.request_latch, int_req, lnk.irq_line, lnk.error_event_status, lnk.slot_event_status}, 28'h0);
      $display("row %0d done", i);
    end
    // combined request held: a later source must not relatch
    wr(cevi_pkg::REG_REQUEST_LATCH_ENABLE, 16'h0002);
    ev(3, 4'h1);
    chk({lnk.request_latch, int_req}, 6'h3A);
    svc(3'h0, 16'hFFFF, 3'h7);
    ev(4, 4'h0);
    chk({lnk.request_latch, lnk.irq_line, lnk.error_event_status}, 9'h039);
    svc(3'h0, 16'h0000, 3'h0);
    chk(lnk.irq_line, 3'h0);
    $display("combined hold done");
    // split mode: own latch per request, rx re-armed by latch alone
    wr(cevi_pkg::REG_REQUEST_LATCH_ENABLE, 16'h0007);
    wr(cevi_pkg::REG_MODULE_CONTROL_ONE, 16'h0001);
    ev(0, 4'h2);
    ev(1, 4'h2);
    ev(2, 4'h2);
    chk({lnk.request_latch, int_req}, 6'h09);
    ev(3, 4'h4);
    chk({lnk.request_latch, int_req}, 6'h1B);
    ev(4, 4'h0);
    chk(lnk.request_latch, 3'h7);
    svc(3'h6, 16'hFFFF, 3'h7);
    chk(lnk.request_latch, 3'h7);
    svc(3'h3, 16'hFFFF, 3'h7);
    ev(5, 4'h0);
    chk({lnk.request_latch[2], lnk.error_event_status}, 4'h3);
    svc(3'h0, 16'h0000, 3'h0);
    chk(lnk.request_latch, 3'h0);
    wr(cevi_pkg::REG_ERROR_EVENT_MASK, 16'h0000);
    ev(6, 4'h0);
    chk({lnk.request_latch, lnk.irq_line, lnk.error_event_status}, 9'h004);
    $display("split mode done");
    // reception refused on a slot without receive request
    ev(0, 4'hF);
    chk(lnk.module_status[0], 1'b1);
    ev(1, 4'hF);
    chk({lnk.new_message_flag[15], lnk.slot_update_in_progress[15], lnk.module_status[0]}, 3'h0);
    $display("refused reception done");
    // software clears of the module flags and the per-slot flags
    wr(cevi_pkg::REG_MODULE_STATUS, 16'h0000);
    wr(cevi_pkg::REG_NEW_MESSAGE, 16'h0000);
    chk(lnk.module_status[3:0], 4'h0);
    chk({lnk.new_message_flag, lnk.sent_flag}, 32'h0);
    $display("flag clear done");
    // reset in mid-run clears the held error status
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk({lnk.error_event_status, lnk.request_latch, int_req}, 9'h000);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    $display("mid-run reset done");
    test_done();
  end

  // watchdog, well above the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    test_done();
  end
endmodule : test_can_event_interrupt_logic
